// ### inc/uartc_pkg.sv
// constants and types shared by the uart channel
package uartc_pkg;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned OVS        = 16;
   // register offsets inside one channel window
   localparam logic [4:0]  OFS_DATA   = 5'h00;
   localparam logic [4:0]  OFS_IER    = 5'h04;
   localparam logic [4:0]  OFS_IIR    = 5'h08;
   localparam logic [4:0]  OFS_LCR    = 5'h0c;
   localparam logic [4:0]  OFS_LSR    = 5'h14;
   localparam logic [31:0] CH_SPAN    = 32'h0000_0020;
   // reset values
   localparam logic [7:0]  IER_RST    = 8'h00;
   localparam logic [7:0]  LCR_RST    = 8'h00;
   localparam logic [7:0]  DIV_RST    = 8'h00;
   localparam logic [1:0]  RX_TRIGGER_LEVEL_RST   = 2'h0;
   // field positions
   localparam int unsigned LCR_DIVISOR_ACCESS_BIT   = 7;
   localparam int unsigned LCR_BRK    = 6;
   localparam int unsigned LCR_STICK  = 5;
   localparam int unsigned LCR_EVEN   = 4;
   localparam int unsigned LCR_PEN    = 3;
   localparam int unsigned LCR_STB    = 2;
   localparam int unsigned FCR_EN     = 0;
   localparam int unsigned FCR_RFL    = 1;
   localparam int unsigned FCR_TFL    = 2;
   localparam int unsigned IER_RDA    = 0;
   localparam int unsigned IER_THR    = 1;
   localparam int unsigned IER_RLS    = 2;
   // interrupt codes
   localparam logic [3:0]  IID_NONE   = 4'h1;
   localparam logic [3:0]  IID_RLS    = 4'h6;
   localparam logic [3:0]  IID_RDA    = 4'h4;
   localparam logic [3:0]  IID_CTO    = 4'hc;
   localparam logic [3:0]  IID_THRE   = 4'h2;
   // receive trigger levels
   localparam int unsigned TRIG_0     = 1;
   localparam int unsigned TRIG_1     = 4;
   localparam int unsigned TRIG_2     = 8;
   localparam int unsigned TRIG_3     = 14;
   // bit timing in oversample ticks
   localparam logic [4:0]  BIT_LAST   = 5'(OVS - 1);
   localparam logic [4:0]  MID_LAST   = 5'(OVS / 2 - 1);
   localparam logic [4:0]  STOP15_LST = 5'(OVS * 3 / 2 - 1);
   localparam logic [4:0]  STOP2_LST  = 5'(OVS * 2 - 1);
   localparam logic [1:0]  AXI_OKAY   = 2'h0;
   typedef enum logic [4:0] {
      TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
   } uartc_tx_t;
   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
   } uartc_rx_t;
endpackage : uartc_pkg

// ### rtl/uartc_top.sv
// one uart channel with fifos behind an axi4-lite slave
// Summary of operation
// - bit rate is clock over sixteen times the sixteen-bit divisor.
// - divisor access bit maps offsets 0x00/0x04 to divisor bytes.
// - offset 0x08 reads ident or fifo control; writes fifo control with access bit clear.
// - ident codes 0001 none, 0110, 0100, 1100, 0010 by priority.
// - line status interrupt on errors, removed by line status read.
// - received data interrupt follows data available or trigger level.
// - timeout in fifo mode after four idle character times with data; read clears.
// - transmit empty interrupt cleared by ident read or transmit write.
// - enable bits 2,1,0 gate line status, transmit empty, received data.
// - ident bits 7:6 read 11 in fifo mode, else 00.
// - fifo control 7:6 pick trigger of 1, 4, 8 or 14.
// - fifo control bits 2 and 1 flush transmit and receive fifos.
// - fifo enable off gives single byte buffering.
// - break bit forces serial output low, transmitter keeps running.
// - stick parity sends and checks 0 when even, 1 when odd.
// - even select picks even parity, else odd.
// - sixteen-entry transmit and receive fifos.
// - one, one and a half or two stops; break sent and detected.
// - channels repeat every 0x20 bytes.
// - offsets 0x10, 0x18, 0x1c reserved.
// - format 00011 is 8N1, 11011 is 8E1.
// - length select 00..11 gives five to eight data bits.
// - two stops with five bits sends one and a half.
// - error flags clear on line status read.
// - data ready while any received data unread.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module uartc_top #(
   parameter int unsigned DEPTH = uartc_pkg::FIFO_DEPTH,
   parameter int unsigned AW    = 12
) (
   // clock and reset
   input  wire logic          ref_clk_i,
   input  wire logic          rstn_i,
   // axi4-lite write
   input  wire logic [AW-1:0] s_axi_awaddr_i,
   input  wire logic          s_axi_awvalid_i,
   output logic               s_axi_awready_o,
   input  wire logic [31:0]   s_axi_wdata_i,
   input  wire logic [3:0]    s_axi_wstrb_i,
   input  wire logic          s_axi_wvalid_i,
   output logic               s_axi_wready_o,
   output logic [1:0]         s_axi_bresp_o,
   output logic               s_axi_bvalid_o,
   input  wire logic          s_axi_bready_i,
   // axi4-lite read
   input  wire logic [AW-1:0] s_axi_araddr_i,
   input  wire logic          s_axi_arvalid_i,
   output logic               s_axi_arready_o,
   output logic [31:0]        s_axi_rdata_o,
   output logic [1:0]         s_axi_rresp_o,
   output logic               s_axi_rvalid_o,
   input  wire logic          s_axi_rready_i,
   // serial line and interrupt
   input  wire logic          rxd_i,
   output logic               txd_o,
   output logic               intr_o
);
   import uartc_pkg::*;

   localparam int unsigned IW = $clog2(DEPTH);
   localparam int unsigned CW = IW + 1;

   typedef struct packed {
      logic                     aw_hold;
      logic [4:0]               aw_adr;
      logic                     w_hold;
      logic                     w_en;
      logic [7:0]               w_dat;
      logic                     bvalid;
      logic                     rvalid;
      logic [7:0]               rdata;
      logic [7:0]               interrupt_enable;
      logic [7:0]               line_control;
      logic [7:0]               dll;
      logic [7:0]               divisor_high_byte;
      logic [1:0]               rx_trigger_level;
      logic                     fen;
      logic [15:0]              bdc;
      logic [DEPTH-1:0][7:0]    rmem;
      logic [IW-1:0]            rwp;
      logic [IW-1:0]            rrp;
      logic [CW-1:0]            rcnt;
      logic [DEPTH-1:0][7:0]    tmem;
      logic [IW-1:0]            twp;
      logic [IW-1:0]            trp;
      logic [CW-1:0]            tcnt;
      logic                     oe;
      logic                     pe;
      logic                     fe;
      logic                     bi;
      logic                     eif;
      logic                     thre_irq;
      logic                     cto;
      logic [9:0]               tmo;
      uartc_tx_t                tst;
      logic [4:0]               ttk;
      logic [2:0]               tbit;
      logic [7:0]               tsh;
      logic                     tpar;
      logic                     txd;
      logic                     txo;
      uartc_rx_t                rst;
      logic [4:0]               rtk;
      logic [2:0]               rbit;
      logic [7:0]               rsh;
      logic                     rpar;
      logic [2:0]               sync;
      logic                     rxl;
      logic                     rarm;
   } uartc_st_t;

   uartc_st_t     s;
   uartc_st_t     n;
   logic [15:0]   div;
   logic          tick;
   logic          divisor_access_bit;
   logic          parity_enable;
   logic [CW-1:0] cap;
   logic [CW-1:0] trig;
   logic [2:0]    wlast;
   logic [4:0]    stop_last;
   logic [3:0]    frame;
   logic [9:0]    tmo_lim;
   logic          rls_p;
   logic          rda_p;
   logic          cto_p;
   logic          thr_p;
   logic [3:0]    code;
   logic          ar_take;
   logic          wr;
   logic          rpush;
   logic          rpop;
   logic          rfull;
   logic          rflush;
   logic          tpush;
   logic          tpop;
   logic          tflush;
   logic [7:0]    rx_dat;
   logic          rx_fe;
   logic          rx_pe;

   // parity of the active data bits for the programmed format
   function automatic logic par_f(input logic [7:0] d, input logic [7:0] lc);
      logic p;
      p = ^(d & (8'hff >> (2'd3 - lc[1:0])));
      if (lc[LCR_STICK])
         return ~lc[LCR_EVEN];
      return lc[LCR_EVEN] ? p : ~p;
   endfunction : par_f

   assign s_axi_awready_o = !s.aw_hold && !s.bvalid;
   assign s_axi_wready_o  = !s.w_hold && !s.bvalid;
   assign s_axi_bvalid_o  = s.bvalid;
   assign s_axi_bresp_o   = AXI_OKAY;
   assign s_axi_arready_o = !s.rvalid;
   assign s_axi_rvalid_o  = s.rvalid;
   assign s_axi_rresp_o   = AXI_OKAY;
   assign s_axi_rdata_o   = {24'h0, s.rdata};
   assign txd_o           = s.txo;
   assign intr_o          = code != IID_NONE;
   assign ar_take         = s_axi_arvalid_i && !s.rvalid;
   assign wr              = s.aw_hold && s.w_hold && s.w_en;

   always_comb begin
      n = s;
      rpush = 1'b0;
      rpop = 1'b0;
      rflush = 1'b0;
      tpush = 1'b0;
      tpop = 1'b0;
      tflush = 1'b0;
      divisor_access_bit = s.line_control[LCR_DIVISOR_ACCESS_BIT];
      parity_enable = s.line_control[LCR_PEN];
      div = {s.divisor_high_byte, s.dll};
      tick = (div != 16'h0) && (s.bdc >= div - 16'h1);
      n.bdc = tick ? 16'h0 : s.bdc + 16'h1;
      cap = s.fen ? CW'(DEPTH) : CW'(1);
      rfull = s.rcnt >= cap;
      case (s.rx_trigger_level)
         2'd0: trig = CW'(TRIG_0);
         2'd1: trig = CW'(TRIG_1);
         2'd2: trig = CW'(TRIG_2);
         default: trig = CW'(TRIG_3);
      endcase
      wlast = 3'd4 + {1'b0, s.line_control[1:0]};
      if (!s.line_control[LCR_STB])
         stop_last = BIT_LAST;
      else if (s.line_control[1:0] == 2'd0)
         stop_last = STOP15_LST;
      else
         stop_last = STOP2_LST;
      frame = 4'd7 + {2'b0, s.line_control[1:0]} + {3'b0, parity_enable} + {3'b0, s.line_control[LCR_STB]};
      tmo_lim = {frame, 6'h0};
      rls_p = s.interrupt_enable[IER_RLS] && (s.oe || s.pe || s.fe || s.bi);
      rda_p = s.interrupt_enable[IER_RDA] && (s.fen ? s.rcnt >= trig : s.rcnt != '0);
      cto_p = s.interrupt_enable[IER_RDA] && s.cto;
      thr_p = s.interrupt_enable[IER_THR] && s.thre_irq;
      if (rls_p)
         code = IID_RLS;
      else if (rda_p)
         code = IID_RDA;
      else if (cto_p)
         code = IID_CTO;
      else if (thr_p)
         code = IID_THRE;
      else
         code = IID_NONE;

      // bus write side: address and data taken in either order
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         n.aw_hold = 1'b1;
         n.aw_adr = s_axi_awaddr_i[4:0];
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         n.w_hold = 1'b1;
         n.w_dat = s_axi_wdata_i[7:0];
         n.w_en = s_axi_wstrb_i[0];
      end
      if (s.bvalid && s_axi_bready_i)
         n.bvalid = 1'b0;
      if (s.aw_hold && s.w_hold) begin
         n.aw_hold = 1'b0;
         n.w_hold = 1'b0;
         n.bvalid = 1'b1;
      end
      if (wr) begin
         case (s.aw_adr)
            OFS_DATA: begin
               if (divisor_access_bit)
                  n.dll = s.w_dat;
               else
                  tpush = 1'b1;
            end
            OFS_IER: begin
               if (divisor_access_bit)
                  n.divisor_high_byte = s.w_dat;
               else
                  n.interrupt_enable = {5'h0, s.w_dat[2:0]};
            end
            OFS_IIR: begin
               if (!divisor_access_bit) begin
                  n.fen = s.w_dat[FCR_EN];
                  n.rx_trigger_level = s.w_dat[7:6];
                  rflush = s.w_dat[FCR_RFL] || (s.w_dat[FCR_EN] != s.fen);
                  tflush = s.w_dat[FCR_TFL] || (s.w_dat[FCR_EN] != s.fen);
               end
            end
            OFS_LCR: n.line_control = s.w_dat;
            default: n.line_control = s.line_control;
         endcase
      end

      // bus read side with its side effects
      if (s.rvalid && s_axi_rready_i)
         n.rvalid = 1'b0;
      if (ar_take) begin
         n.rvalid = 1'b1;
         n.rdata = 8'h00;
         case (s_axi_araddr_i[4:0])
            OFS_DATA: begin
               if (divisor_access_bit)
                  n.rdata = s.dll;
               else begin
                  n.rdata = s.rmem[s.rrp];
                  rpop = s.rcnt != '0;
               end
            end
            OFS_IER: n.rdata = divisor_access_bit ? s.divisor_high_byte : s.interrupt_enable;
            OFS_IIR: begin
               if (divisor_access_bit)
                  n.rdata = {s.rx_trigger_level, 5'h0, s.fen};
               else begin
                  n.rdata = {{2{s.fen}}, 2'b00, code};
                  if (code == IID_THRE)
                     n.thre_irq = 1'b0;
               end
            end
            OFS_LCR: n.rdata = s.line_control;
            OFS_LSR: begin
               n.rdata = {s.eif, (s.tcnt == '0) && (s.tst == TX_IDLE), s.tcnt == '0,
                          s.bi, s.fe, s.pe, s.oe, s.rcnt != '0};
               n.oe = 1'b0;
               n.pe = 1'b0;
               n.fe = 1'b0;
               n.bi = 1'b0;
               n.eif = 1'b0;
            end
            default: n.rdata = 8'h00;
         endcase
      end

      // transmitter; break only masks the pin, so frames still complete
      if (tick) begin
         n.ttk = s.ttk + 5'd1;
         case (s.tst)
            TX_IDLE: begin
               n.ttk = 5'd0;
               if (s.tcnt != '0) begin
                  tpop = 1'b1;
                  n.tsh = s.tmem[s.trp];
                  n.txd = 1'b0;
                  n.tst = TX_START;
               end
            end
            TX_START: begin
               if (s.ttk == BIT_LAST) begin
                  n.ttk = 5'd0;
                  n.tbit = 3'd0;
                  n.txd = s.tsh[0];
                  n.tpar = par_f(s.tsh, s.line_control);
                  n.tst = TX_DATA;
               end
            end
            TX_DATA: begin
               if (s.ttk == BIT_LAST) begin
                  n.ttk = 5'd0;
                  n.tsh = s.tsh >> 1;
                  n.tbit = s.tbit + 3'd1;
                  n.txd = s.tsh[1];
                  if (s.tbit == wlast) begin
                     n.tst = parity_enable ? TX_PAR : TX_STOP;
                     n.txd = parity_enable ? s.tpar : 1'b1;
                  end
               end
            end
            TX_PAR: begin
               if (s.ttk == BIT_LAST) begin
                  n.ttk = 5'd0;
                  n.txd = 1'b1;
                  n.tst = TX_STOP;
               end
            end
            TX_STOP: begin
               if (s.ttk == stop_last) begin
                  n.ttk = 5'd0;
                  n.tst = TX_IDLE;
               end
            end
            default: n.tst = TX_IDLE;
         endcase
      end

      // receiver: three-flop sync, level accepted when stages two and three agree
      n.sync = {s.sync[1:0], rxd_i};
      if (s.sync[1] == s.sync[2])
         n.rxl = s.sync[2];
      if (s.rst == RX_IDLE && s.rxl)
         n.rarm = 1'b1;
      rx_dat = s.rsh >> (2'd3 - s.line_control[1:0]);
      rx_fe = !s.rxl;
      rx_pe = parity_enable && (s.rpar != par_f(rx_dat, s.line_control));
      if (tick) begin
         n.rtk = s.rtk + 5'd1;
         case (s.rst)
            RX_IDLE: begin
               n.rtk = 5'd0;
               if (!s.rxl && s.rarm) begin
                  n.rarm = 1'b0;
                  n.rst = RX_START;
               end
            end
            RX_START: begin
               if (s.rtk == MID_LAST) begin
                  n.rtk = 5'd0;
                  n.rbit = 3'd0;
                  n.rst = s.rxl ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (s.rtk == BIT_LAST) begin
                  n.rtk = 5'd0;
                  n.rsh = {s.rxl, s.rsh[7:1]};
                  n.rbit = s.rbit + 3'd1;
                  if (s.rbit == wlast)
                     n.rst = parity_enable ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: begin
               if (s.rtk == BIT_LAST) begin
                  n.rtk = 5'd0;
                  n.rpar = s.rxl;
                  n.rst = RX_STOP;
               end
            end
            RX_STOP: begin
               if (s.rtk == BIT_LAST) begin
                  n.rtk = 5'd0;
                  n.rarm = 1'b0;
                  rpush = 1'b1;
                  n.rst = RX_IDLE;
               end
            end
            default: n.rst = RX_IDLE;
         endcase
      end
      if (rpush) begin
         if (rfull)
            n.oe = 1'b1;
         n.pe = s.pe || rx_pe;
         n.fe = s.fe || rx_fe;
         n.bi = s.bi || (rx_fe && rx_dat == 8'h00 && !(parity_enable && s.rpar));
         n.eif = s.eif || (s.fen && (rx_fe || rx_pe));
      end

      if (rflush) begin
         n.rcnt = '0;
         n.rwp = '0;
         n.rrp = '0;
      end else begin
         if (rpush && !rfull) begin
            n.rmem[s.rwp] = rx_dat;
            n.rwp = s.rwp + IW'(1);
         end
         if (rpop)
            n.rrp = s.rrp + IW'(1);
         n.rcnt = s.rcnt + CW'(rpush && !rfull) - CW'(rpop);
      end
      // transmit fifo; a write to a full fifo is dropped
      if (tflush) begin
         n.tcnt = '0;
         n.twp = '0;
         n.trp = '0;
      end else begin
         if (tpush && s.tcnt < cap) begin
            n.tmem[s.twp] = s.w_dat;
            n.twp = s.twp + IW'(1);
         end
         if (tpop)
            n.trp = s.trp + IW'(1);
         n.tcnt = s.tcnt + CW'(tpush && s.tcnt < cap) - CW'(tpop);
      end

      if (tpush)
         n.thre_irq = 1'b0;
      if ((n.tcnt == '0 && s.tcnt != '0) ||
          (wr && s.aw_adr == OFS_IER && !divisor_access_bit && s.w_dat[IER_THR] && n.tcnt == '0))
         n.thre_irq = 1'b1;

      if (rpush || rpop || s.rcnt == '0)
         n.tmo = 10'h0;
      else if (tick && s.tmo != tmo_lim)
         n.tmo = s.tmo + 10'h1;
      if (rpop || rflush || s.rcnt == '0)
         n.cto = 1'b0;
      else if (s.fen && s.tmo == tmo_lim && !rpush)
         n.cto = 1'b1;

      n.txo = n.txd && !n.line_control[LCR_BRK];
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= '0;
         s.interrupt_enable <= IER_RST;
         s.line_control <= LCR_RST;
         s.dll <= DIV_RST;
         s.divisor_high_byte <= DIV_RST;
         s.rx_trigger_level <= RX_TRIGGER_LEVEL_RST;
         s.tst <= TX_IDLE;
         s.rst <= RX_IDLE;
         s.txd <= 1'b1;
         s.txo <= 1'b1;
      end else begin
         s <= n;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_lsr_rd;
      ar_take && s_axi_araddr_i[4:0] == OFS_LSR && !rpush;
   endsequence
   sequence s_iir_rd;
      ar_take && s_axi_araddr_i[4:0] == OFS_IIR && !divisor_access_bit;
   endsequence

   chk_brk_low: assert property (s.line_control[LCR_BRK] |-> !txd_o)
      else $error("break set but serial output high");
   chk_lsr_clear: assert property (s_lsr_rd |=> !(s.oe || s.pe || s.fe || s.bi))
      else $error("line status read left an error flag");
   chk_rls_gone: assert property (s_lsr_rd |=> code != IID_RLS)
      else $error("line status interrupt survived its read");
   chk_thre_clear: assert property (tpush |=> !s.thre_irq)
      else $error("transmit empty interrupt survived a write");
   chk_iir_fifo: assert property (s_iir_rd |=> s.rvalid && s.rdata[7:6] == {2{$past(s.fen)}})
      else $error("ident bits 7:6 do not match fifo mode");
   // flush empties
   // receiver keeps its own course through a flush; only the fifo empties
   chk_rx_flush: assert property (rflush |=> s.rcnt == '0 && s.rst == $past(n.rst))
      else $error("receive flush did not empty fifo");
   chk_cap_byte: assert property (!s.fen && !$past(s.fen) |-> s.rcnt <= 1 && s.tcnt <= 1)
      else $error("more than one byte held outside fifo mode");
   chk_iir_prio: assert property (rls_p && (rda_p || thr_p) |-> intr_o && code == IID_RLS)
      else $error("line status not reported first");
   chk_dr_set: assert property (rpush && !rfull && !rflush |=> s.rcnt != '0)
      else $error("stored character left data ready low");
   chk_baud_tick: assert property (tick && div > 16'h1 |=> !tick)
      else $error("baud ticks closer than the divisor");
endmodule : uartc_top

// ### sim/uartc_peer.sv
// serial peer model that sends frames to the channel and captures its output
`timescale 1ns/1ps
module uartc_peer #(
   parameter int unsigned BIT_CLKS = 16
) (
   // clock and line
   input  wire logic ref_clk_i,
   input  wire logic line_i,
   output logic      line_o
);
   initial begin
      line_o = 1'b1;
   end
   task automatic send(input logic [7:0] d, input logic par_en, input logic par);
      logic [10:0] f;
      f = {1'b1, par, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         if (i != 9 || par_en) begin
            line_o <= f[i];
            repeat (BIT_CLKS) @(posedge ref_clk_i);
         end
      end
   endtask : send
   task automatic capture(output logic [7:0] d);
      @(negedge line_i);
      repeat (BIT_CLKS / 2) @(posedge ref_clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge ref_clk_i);
         d[i] = line_i;
      end
      repeat (BIT_CLKS) @(posedge ref_clk_i);
   endtask : capture
endmodule : uartc_peer

// ### sim/tb_uartc_top.sv
// self-checking bench for the uart channel
`timescale 1ns/1ps
module tb_uartc_top;
   import uartc_pkg::*;
   typedef struct packed {logic wr; logic [11:0] a; logic [7:0] d;} uartc_row_t;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] aw = '0;
   logic [11:0] ar = '0;
   logic [31:0] wd = '0;
   logic        awv = 1'b0;
   logic        wv = 1'b0;
   logic        bq = 1'b0;
   logic        arv = 1'b0;
   logic        rq = 1'b0;
   logic        awr, wrr, bv, arr, rv, txd, rxd, irq;
   logic [1:0]  br, rr;
   logic [31:0] rdat;
   logic [7:0]  got;
   int          err_count = 0;
   int          tests_run = 0;
   // divisor 1 gives sixteen clocks per bit
   uartc_row_t  rows [21] = '{'{0, 12'h004, 8'h00}, '{0, 12'h008, 8'h01}, '{0, 12'h00c, 8'h00},
      '{0, 12'h014, 8'h60}, '{0, 12'h010, 8'h00}, '{0, 12'h018, 8'h00}, '{0, 12'h01c, 8'h00},
      '{1, 12'h00c, 8'h83}, '{1, 12'h000, 8'h01}, '{1, 12'h004, 8'h00}, '{0, 12'h000, 8'h01},
      '{0, 12'h004, 8'h00}, '{0, 12'h008, 8'h00}, '{1, 12'h00c, 8'h03}, '{1, 12'h008, 8'hc1},
      '{0, 12'h008, 8'hc1}, '{0, 12'h02c, 8'h03}, '{1, 12'h004, 8'h07}, '{0, 12'h008, 8'hc2},
      '{0, 12'h008, 8'hc1}, '{0, 12'h004, 8'h07}};
   // lcr, data, parity bit, ident, status
   logic [39:0] cases [4] = '{40'h1b_55_01_c6_e5, 40'h0b_55_01_c1_61,
      40'h3b_55_00_c1_61, 40'h2b_55_01_c1_61};
   always #20 clk = ~clk;
   uartc_top i_uartc_top (
      .ref_clk_i(clk), .rstn_i(rst_n), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wrr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bq),
      .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
      .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rq), .rxd_i(rxd),
      .txd_o(txd), .intr_o(irq));
   uartc_peer #(.BIT_CLKS(16)) i_uartc_peer (.ref_clk_i(clk), .line_i(txd), .line_o(rxd));
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
         err_count++;
      end
   endtask : check
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   // ready is sampled at the falling edge, where it is settled
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic da;
      logic dw;
      da = 1'b0;
      dw = 1'b0;
      @(posedge clk);
      aw <= a;
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bq <= 1'b1;
      while (!(da && dw)) begin
         @(negedge clk);
         da = da || awr;
         dw = dw || wrr;
         @(posedge clk);
         if (da) awv <= 1'b0;
         if (dw) wv <= 1'b0;
      end
      @(negedge clk);
      while (bv !== 1'b1) @(negedge clk);
      check({6'h0, br}, 8'h00);
      @(posedge clk);
      bq <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      logic k;
      k = 1'b0;
      @(posedge clk);
      ar <= a;
      arv <= 1'b1;
      rq <= 1'b1;
      while (!k) begin
         @(negedge clk);
         k = arr;
         @(posedge clk);
      end
      arv <= 1'b0;
      @(negedge clk);
      while (rv !== 1'b1) @(negedge clk);
      d = rdat[7:0];
      check({6'h0, rr}, 8'h00);
      @(posedge clk);
      rq <= 1'b0;
   endtask : rd
   task automatic rc(input logic [11:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      check(d, e);
   endtask : rc
   initial begin
      repeat (10000) @(posedge clk);
      err_count++;
      end_sim();
   end
   initial begin
      repeat (8) @(posedge clk);
      check(txd, 1'b1);
      check(irq, 1'b0);
      rst_n <= 1'b1;
      // receiver arms only after seeing an idle line
      repeat (8) @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         else rc(rows[i].a, rows[i].d);
      end
      fork
         i_uartc_peer.capture(got);
         wr(12'h000, 8'ha5);
      join
      check(got, 8'ha5);
      repeat (4) @(posedge clk);
      check(irq, 1'b1);
      rc(12'h008, 8'hc2);
      rc(12'h008, 8'hc1);
      i_uartc_peer.send(8'h3c, 1'b0, 1'b0);
      repeat (500) @(posedge clk);
      rc(12'h008, 8'hc1);
      repeat (300) @(posedge clk);
      rc(12'h008, 8'hcc);
      wr(12'h008, 8'hc3);
      rc(12'h014, 8'h60);
      rd(12'h008, got);
      foreach (cases[i]) begin
         wr(12'h00c, cases[i][39:32]);
         i_uartc_peer.send(cases[i][31:24], cases[i][35], cases[i][16]);
         repeat (20) @(posedge clk);
         rc(12'h008, cases[i][15:8]);
         rc(12'h014, cases[i][7:0]);
         rc(12'h000, cases[i][31:24]);
         rc(12'h014, 8'h60);
      end
      // transmit flush drops the waiting second byte while the first is still on the line
      wr(12'h000, 8'h11);
      wr(12'h000, 8'h22);
      wr(12'h008, 8'hc5);
      rc(12'h014, 8'h20);
      repeat (200) @(posedge clk);
      rc(12'h014, 8'h60);
      wr(12'h00c, 8'h43);
      repeat (2) @(posedge clk);
      check(txd, 1'b0);
      wr(12'h00c, 8'h03);
      repeat (2) @(posedge clk);
      check(txd, 1'b1);
      end_sim();
   end
endmodule : tb_uartc_top
